// [shared/scc_pkg.sv]
package scc_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] SCC_OSC = 8'h00;
   localparam logic [7:0] SCC_CFG = 8'h04;
   localparam logic [7:0] SCC_TRIM = 8'h08;
   localparam logic [7:0] SCC_STAT = 8'h0C;
   localparam logic [7:0] SCC_GATE = 8'h10;
   localparam logic [7:0] SCC_LPKEEP = 8'h14;
   localparam logic [7:0] SCC_PLL = 8'h18;
   localparam logic [7:0] SCC_CLR = 8'h1C;
   localparam logic [7:0] SCC_KSEL = 8'h20;
   // Oscillator control field positions
   localparam int OSC_FE_ON = 0;
   localparam int OSC_FE_BYP = 1;
   localparam int OSC_FI_ON = 2;
   localparam int OSC_MS_ON = 3;
   localparam int OSC_MS_RNG = 4;
   localparam int OSC_MS_HWT = 8;
   localparam int OSC_SE_ON = 9;
   localparam int OSC_SE_BYP = 10;
   localparam int OSC_SE_DRV = 11;
   localparam int OSC_FMON = 13;
   // Configuration field positions
   localparam int CFG_SW = 0;
   localparam int CFG_CPUDIV = 2;
   localparam int CFG_BUSDIV = 6;
   localparam int CFG_RTC = 10;
   localparam int CFG_PLLREF = 11;
   // Trim field positions and widths
   localparam int TRIM_FI = 0;
   localparam int TRIM_MS = 8;
   localparam int FI_TRIM_W = 5;
   localparam int MS_TRIM_W = 8;
   // Reset values
   localparam logic [31:0] OSC_RESET = 32'h0000_0068;
   localparam logic [31:0] GATE_RESET = 32'h0000_0003;
   localparam logic [FI_TRIM_W-1:0] FI_TRIM_MID = 5'h10;
   localparam logic [MS_TRIM_W-1:0] MS_TRIM_MID = 8'h80;
   // Multispeed range codes: twelve settings, code 6 is 4 MHz
   localparam logic [3:0] MS_RNG_4MHZ = 4'h6;
   localparam logic [3:0] MS_RNG_MAX = 4'hB;
   // Master clock sources
   typedef enum logic [1:0] {
      SRC_MS = 2'b00,
      SRC_FI = 2'b01,
      SRC_FE = 2'b10,
      SRC_PLL = 2'b11
   } scc_src_t;
   // Kernel source code that picks the multispeed RC
   localparam logic [1:0] KSEL_MS = 2'b11;
   localparam logic [1:0] KSEL_PLL = 2'b00;
   localparam int USB_KSEL = 0;
   // Sizes
   localparam int NUM_PLL = 3;
   localparam int PLL_OUTS = 3;
   localparam int NUM_GATE = 16;
   localparam int NUM_KSRC = 9;
   localparam int DIV_W = 9;
   localparam int NUM_SYNC = 12;
   // Clock switch drain time
   localparam int CLK_MHZ = 100;
   localparam int DRAIN_NS = 20;
   localparam int DRAIN_CYC = (DRAIN_NS * CLK_MHZ + 999) / 1000;
endpackage : scc_pkg

// [hdl/scc_top.sv]
`timescale 1ns/1ns
// How it works
// - Master clock picks one of four sources
// - Fast external osc: enable, bypass, PLL feed
// - Fast internal RC trimmable, usable PLL reference
// - Multispeed RC: twelve ranges, trim, PLL feed
// - Hardware trims multispeed RC from slow osc
// - Trimmed multispeed RC may clock USB
// - PLL reference from three fast sources
// - Slow external osc: four drives, bypass
// - Slow internal RC feeds watchdog, RTC option
// - RTC selects slow external or internal
// - Peripheral kernel clocks selected independently
// - Three PLLs with three enabled outputs
// - Reset: multispeed RC at 4 MHz
// - Source switch glitch free
// - CPU and bus prescalers programmable anytime
// - Per-target gates, automatic in low power
// - Fast external failure falls back to RC
module scc_top
   import scc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic fe_rdy,
   input wire logic fi_rdy,
   input wire logic ms_rdy,
   input wire logic [NUM_PLL-1:0] pll_rdy,
   input wire logic se_rdy,
   input wire logic si_rdy,
   input wire logic fe_fail,
   input wire logic se_clk,
   input wire logic ms_fast,
   input wire logic ms_slow,
   input wire logic low_power,
   output logic [31:0] osc_ctrl,
   output logic slow_int_on,
   output logic [FI_TRIM_W-1:0] fi_trim,
   output logic [MS_TRIM_W-1:0] ms_trim,
   output logic [1:0] master_sel,
   output logic master_run,
   output logic cpu_en,
   output logic bus_en,
   output logic [NUM_GATE-1:0] gate_en,
   output logic [1:0] pll_ref,
   output logic [NUM_PLL*PLL_OUTS-1:0] pll_out_en,
   output logic [2*NUM_KSRC-1:0] ksel,
   output logic rtc_sel,
   output logic fail_irq
);
   typedef enum {ST_RUN, ST_DRAIN, ST_RESUME} scc_sw_t;

   // Input synchroniser: three stages, value moves once 2nd and 3rd agree
   logic [NUM_SYNC-1:0] s1, s2, s3, sf;
   logic [NUM_SYNC-1:0] next_sf, raw_in;
   assign raw_in = {ms_slow, ms_fast, se_clk, fe_fail, si_rdy, se_rdy,
                    pll_rdy, ms_rdy, fi_rdy, fe_rdy};
   always_comb
   begin
      next_sf = (s2 & s3) | (sf & (s2 | s3));
   end
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         sf <= '0;
      end
      else
      begin
         s1 <= raw_in;
         s2 <= s1;
         s3 <= s2;
         sf <= next_sf;
      end
   end

   logic f_fe, f_fi, f_ms, f_se, f_fail, f_seclk, f_fast, f_slow;
   logic [NUM_PLL-1:0] f_pll;
   assign {f_slow, f_fast, f_seclk, f_fail} = sf[NUM_SYNC-1:NUM_SYNC-4];
   // Low seven bits keep the order of raw_in: fe, fi, ms, pll, se
   assign {f_se, f_pll, f_ms, f_fi, f_fe} = sf[6:0];

   // Software visible state
   logic [31:0] osc, next_osc, cfg, next_cfg, gate, next_gate;
   logic [31:0] lpkeep, next_lpkeep, pll, next_pll, kreg, next_kreg;
   logic [FI_TRIM_W-1:0] fit, next_fit;
   logic [MS_TRIM_W-1:0] mst, next_mst;
   logic flag, next_flag, fail_d, next_fail_d, seclk_d, next_seclk_d;
   logic [1:0] cur, next_cur;
   scc_sw_t st, next_st;
   logic [1:0] dcnt, next_dcnt;
   logic [31:0] next_rdata;
   logic ready_req, hwt_lock;
   logic [1:0] req;

   assign req = cfg[CFG_SW +: 2];
   // Lock means hardware trim is running against a live slow osc
   assign hwt_lock = osc[OSC_MS_HWT] & f_se & osc[OSC_SE_ON];

   // Ready of the requested source
   always_comb
   begin
      case (req)
         SRC_MS: ready_req = f_ms;
         SRC_FI: ready_req = f_fi;
         SRC_FE: ready_req = f_fe;
         SRC_PLL: ready_req = f_pll[0];
         default: ready_req = 1'b0;
      endcase
   end

   // Register writes, trim, failure handling
   always_comb
   begin
      next_osc = osc;
      next_cfg = cfg;
      next_gate = gate;
      next_lpkeep = lpkeep;
      next_pll = pll;
      next_kreg = kreg;
      next_fit = fit;
      next_mst = mst;
      next_flag = flag;
      next_fail_d = f_fail;
      next_seclk_d = f_seclk;
      if (wr)
      begin
         case (addr)
            SCC_OSC:
            begin
               next_osc = wdata;
               if (wdata[OSC_MS_RNG +: 4] > MS_RNG_MAX)
                  next_osc[OSC_MS_RNG +: 4] = osc[OSC_MS_RNG +: 4];
            end
            SCC_CFG: next_cfg = wdata;
            SCC_TRIM:
            begin
               next_fit = wdata[TRIM_FI +: FI_TRIM_W];
               next_mst = wdata[TRIM_MS +: MS_TRIM_W];
            end
            SCC_GATE: next_gate = wdata;
            SCC_LPKEEP: next_lpkeep = wdata;
            SCC_PLL: next_pll = wdata;
            SCC_KSEL: next_kreg = wdata;
            SCC_CLR: next_flag = flag & ~wdata[0];
            default: next_flag = flag;
         endcase
      end
      // step trim each rising slow osc edge
      if (hwt_lock && f_seclk && !seclk_d)
      begin
         if (f_fast && mst != '0)
            next_mst = mst - MS_TRIM_W'(1);
         else if (f_slow && mst != '1)
            next_mst = mst + MS_TRIM_W'(1);
      end
      // failure detected on rising edge of monitor
      if (osc[OSC_FMON] && f_fail && !fail_d)
      begin
         next_flag = 1'b1;
         if (req == SRC_FE || (req == SRC_PLL && cfg[CFG_PLLREF +: 2] == SRC_FE))
            next_cfg[CFG_SW +: 2] = SRC_FI;
      end
   end

   // Source switch: gate off, drain, change, resume; fast external failure changes at once, no drain
   always_comb
   begin
      next_st = st;
      next_cur = cur;
      next_dcnt = dcnt;
      case (st)
         ST_RUN:
         begin
            if (req != cur && ready_req)
            begin
               next_st = ST_DRAIN;
               next_dcnt = 2'(DRAIN_CYC);
            end
         end
         ST_DRAIN:
         begin
            if (dcnt == 2'd1)
            begin
               next_cur = req;
               next_st = ST_RESUME;
            end
            else
               next_dcnt = dcnt - 2'd1;
         end
         ST_RESUME: next_st = ST_RUN;
         default: next_st = ST_RUN;
      endcase
      if (f_fail && osc[OSC_FMON] && cur == SRC_FE)
      begin
         next_cur = SRC_FI;
         next_st = ST_RESUME;
      end
   end

   // Prescalers: power-of-two ratios, bus derived from CPU enable
   logic [DIV_W-1:0] ccnt, next_ccnt, bcnt, next_bcnt;
   logic next_cpu_en, next_bus_en;
   logic [DIV_W-1:0] cpu_lim, bus_lim;
   assign cpu_lim = DIV_W'((1 << cfg[CFG_CPUDIV +: 4]) - 1);
   assign bus_lim = DIV_W'((1 << cfg[CFG_BUSDIV +: 4]) - 1);
   always_comb
   begin
      next_ccnt = ccnt;
      next_bcnt = bcnt;
      next_cpu_en = 1'b0;
      next_bus_en = 1'b0;
      if (st == ST_RUN)
      begin
         if (ccnt >= cpu_lim)
         begin
            next_ccnt = '0;
            next_cpu_en = 1'b1;
            if (bcnt >= bus_lim)
            begin
               next_bcnt = '0;
               next_bus_en = 1'b1;
            end
            else
               next_bcnt = bcnt + DIV_W'(1);
         end
         else
            next_ccnt = ccnt + DIV_W'(1);
      end
   end

   // Output images
   logic [NUM_GATE-1:0] next_gate_en;
   logic [NUM_PLL*PLL_OUTS-1:0] next_pll_out;
   logic [2*NUM_KSRC-1:0] next_ksel;
   always_comb
   begin
      next_gate_en = gate[NUM_GATE-1:0] &
                     (low_power ? lpkeep[NUM_GATE-1:0] : '1);
      // output needs its PLL on and locked
      for (int i = 0; i < NUM_PLL; i++)
         next_pll_out[i*PLL_OUTS +: PLL_OUTS] =
            pll[i*PLL_OUTS +: PLL_OUTS] &
            {PLL_OUTS{pll[NUM_PLL*PLL_OUTS + i] & f_pll[i]}};
      next_ksel = kreg[2*NUM_KSRC-1:0];
      // multispeed to USB only when locked
      if (next_ksel[USB_KSEL +: 2] == KSEL_MS && !hwt_lock)
         next_ksel[USB_KSEL +: 2] = KSEL_PLL;
   end

   // Read mux, data in the cycle after the strobe
   always_comb
   begin
      next_rdata = '0;
      if (rd)
      begin
         case (addr)
            SCC_OSC: next_rdata = osc;
            SCC_CFG: next_rdata = cfg;
            SCC_TRIM: next_rdata = 32'(fit) | (32'(mst) << TRIM_MS);
            SCC_STAT: next_rdata = {16'h0000, 3'b000, hwt_lock, flag,
                                    st != ST_RUN, f_pll, f_si_pad(),
                                    f_se, f_ms, f_fi, f_fe, cur};
            SCC_GATE: next_rdata = gate;
            SCC_LPKEEP: next_rdata = lpkeep;
            SCC_PLL: next_rdata = pll;
            SCC_KSEL: next_rdata = kreg;
            default: next_rdata = '0;
         endcase
      end
   end

   function automatic logic f_si_pad();
      f_si_pad = sf[7];
   endfunction : f_si_pad

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         // multispeed RC at 4 MHz, divide by one
         osc <= OSC_RESET;
         cfg <= '0;
         gate <= GATE_RESET;
         lpkeep <= '0;
         pll <= '0;
         kreg <= '0;
         fit <= FI_TRIM_MID;
         mst <= MS_TRIM_MID;
         flag <= 1'b0;
         fail_d <= 1'b0;
         seclk_d <= 1'b0;
         cur <= SRC_MS;
         st <= ST_RUN;
         dcnt <= '0;
         ccnt <= '0;
         bcnt <= '0;
         rdata <= '0;
         osc_ctrl <= OSC_RESET;
         slow_int_on <= 1'b0;
         fi_trim <= FI_TRIM_MID;
         ms_trim <= MS_TRIM_MID;
         master_sel <= SRC_MS;
         master_run <= 1'b0;
         cpu_en <= 1'b0;
         bus_en <= 1'b0;
         gate_en <= '0;
         pll_ref <= '0;
         pll_out_en <= '0;
         ksel <= '0;
         rtc_sel <= 1'b0;
         fail_irq <= 1'b0;
      end
      else
      begin
         osc <= next_osc;
         cfg <= next_cfg;
         gate <= next_gate;
         lpkeep <= next_lpkeep;
         pll <= next_pll;
         kreg <= next_kreg;
         fit <= next_fit;
         mst <= next_mst;
         flag <= next_flag;
         fail_d <= next_fail_d;
         seclk_d <= next_seclk_d;
         cur <= next_cur;
         st <= next_st;
         dcnt <= next_dcnt;
         ccnt <= next_ccnt;
         bcnt <= next_bcnt;
         rdata <= next_rdata;
         osc_ctrl <= osc;
         slow_int_on <= 1'b1;
         fi_trim <= fit;
         ms_trim <= mst;
         master_sel <= cur;
         master_run <= (st == ST_RUN);
         cpu_en <= next_cpu_en;
         bus_en <= next_bus_en;
         gate_en <= next_gate_en;
         // reference is MS, FI or FE only
         pll_ref <= (cfg[CFG_PLLREF +: 2] == SRC_PLL) ? SRC_MS :
                    cfg[CFG_PLLREF +: 2];
         pll_out_en <= next_pll_out;
         ksel <= next_ksel;
         rtc_sel <= cfg[CFG_RTC];
         fail_irq <= flag;
      end
   end
endmodule : scc_top

// [bench/scc_osc_model.sv]
`timescale 1ns/1ns
module scc_osc_model
   import scc_pkg::*;
(
   input wire logic clock,
   input wire logic [31:0] osc_ctrl,
   input wire logic slow_int_on,
   input wire logic fail_cmd,
   output logic fe_rdy,
   output logic fi_rdy,
   output logic ms_rdy,
   output logic se_rdy,
   output logic si_rdy,
   output logic [NUM_PLL-1:0] pll_rdy,
   output logic fe_fail,
   output logic se_clk,
   output logic ms_fast,
   output logic ms_slow
);
   logic [31:0] d1;
   logic [31:0] d2;
   logic [3:0] div = 4'h0;
   // Oscillators settle two cycles after enable, slow internal RC at once
   always @(posedge clock)
   begin
      d1 <= osc_ctrl;
      d2 <= d1;
      div <= div + 4'h1;
   end
   assign fe_rdy = d2[OSC_FE_ON] & ~fail_cmd;
   assign fi_rdy = d2[OSC_FI_ON];
   assign ms_rdy = d2[OSC_MS_ON];
   assign se_rdy = d2[OSC_SE_ON];
   assign si_rdy = slow_int_on;
   assign pll_rdy = {NUM_PLL{1'b1}};
   // failure held until bench drops it
   assign fe_fail = fail_cmd;
   // slow clock only while slow osc is on
   assign se_clk = d2[OSC_SE_ON] & div[3];
   // RC reads slow so the trim must keep moving
   assign ms_fast = 1'b0;
   assign ms_slow = 1'b1;
endmodule : scc_osc_model

// [bench/scc_chk_assertions.sv]
`timescale 1ns/1ns
module scc_chk
   import scc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic [31:0] osc_ctrl,
   input wire logic slow_int_on,
   input wire logic [MS_TRIM_W-1:0] ms_trim,
   input wire logic [1:0] master_sel,
   input wire logic master_run,
   input wire logic [2*NUM_KSRC-1:0] ksel,
   input wire logic fail_irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic clr_wr;
   logic trim_wr;
   // Writes that may legally move the flag or the trim
   assign clr_wr = wr && addr == SCC_CLR && wdata[0];
   assign trim_wr = wr && addr == SCC_TRIM;
   // Gate is low at the change and reopens one cycle later
   sequence s_resume;
      !master_run ##1 master_run;
   endsequence
   property p_rst_val;
      $rose(nrst) |-> master_sel == SRC_MS && osc_ctrl == OSC_RESET
         && ms_trim == MS_TRIM_MID;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset state");
   property p_run_up;
      $rose(nrst) |=> master_run && slow_int_on;
   endproperty
   a_run_up: assert property (p_run_up) else $error("no run");
   property p_switch;
      $changed(master_sel) |-> s_resume;
   endproperty
   a_switch: assert property (p_switch) else $error("ungated switch");
   property p_sticky;
      fail_irq && !clr_wr && !$past(clr_wr) |=> fail_irq;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_fail_en;
      $rose(fail_irq) |-> osc_ctrl[OSC_FMON];
   endproperty
   a_fail_en: assert property (p_fail_en) else $error("flag unarmed");
   property p_fallback;
      $rose(fail_irq) && $past(master_sel) == SRC_FE
         |-> ##[0:6] master_sel == SRC_FI;
   endproperty
   a_fallback: assert property (p_fallback) else $error("no fallback");
   property p_usb_ms;
      ksel[1:0] == KSEL_MS |-> osc_ctrl[OSC_MS_HWT] && osc_ctrl[OSC_SE_ON];
   endproperty
   a_usb_ms: assert property (p_usb_ms) else $error("untrimmed usb");
   // Trim output lags the write by two cycles, so look two back
   property p_trim_step;
      $changed(ms_trim) && !$past(trim_wr, 2) |->
         ms_trim == $past(ms_trim) + 8'h01 || ms_trim == $past(ms_trim) - 8'h01;
   endproperty
   a_trim_step: assert property (p_trim_step) else $error("trim jump");
endmodule : scc_chk
bind scc_top scc_chk scc_chk_i (.*);

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
   import scc_pkg::*;
   logic clock, nrst, wr, rd, low_power, fail_cmd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, osc_ctrl, rv;
   logic fe_rdy, fi_rdy, ms_rdy, se_rdy, si_rdy, fe_fail, se_clk;
   logic ms_fast, ms_slow, slow_int_on, master_run, cpu_en, bus_en;
   logic rtc_sel, fail_irq;
   logic [NUM_PLL-1:0] pll_rdy;
   logic [FI_TRIM_W-1:0] fi_trim;
   logic [MS_TRIM_W-1:0] ms_trim;
   logic [1:0] master_sel, pll_ref;
   logic [NUM_GATE-1:0] gate_en;
   logic [NUM_PLL*PLL_OUTS-1:0] pll_out_en;
   logic [2*NUM_KSRC-1:0] ksel;
   int fail_count, tests_run, n, k, b;
   scc_top scc_top_i (.*);
   scc_osc_model scc_osc_model_i (.*);
   // Free-running system clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("ERROR %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wreg
   // Data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : rreg
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask : tick
   task automatic test_done;
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // Hang guard, far beyond the few hundred cycles used
   initial
   begin
      #100000;
      fail_count++;
      test_done();
   end
   initial
   begin
      {nrst, wr, rd, low_power, fail_cmd} = 5'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      fail_count = 0;
      tests_run = 0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      rreg(SCC_OSC);
      chk(rv, OSC_RESET);
      rreg(8'h40);
      chk(rv, 32'h0000_0000);
      // Request an oscillator that is still off
      wreg(SCC_CFG, 32'h0000_0001);
      tick(20);
      chk(master_sel, SRC_MS);
      rreg(SCC_STAT);
      chk(rv[1:0], SRC_MS);
      wreg(SCC_OSC, 32'h0000_006D);
      tick(20);
      chk(master_sel, SRC_FI);
      wreg(SCC_PLL, 32'h0000_0FFF);
      tick(2);
      chk(pll_out_en, 9'h1FF);
      // Walk every master source
      for (n = 3; n >= 0; n--)
      begin
         wreg(SCC_CFG, n);
         tick(20);
         chk(master_sel, n);
      end
      // cpu divide 4, bus divide 2, PLL ref fast ext, RTC slow ext
      wreg(SCC_CFG, 32'h0000_1448);
      tick(4);
      chk(pll_ref, 2'h2);
      chk(rtc_sel, 1'b1);
      k = 0;
      b = 0;
      repeat (64)
      begin
         @(posedge clock);
         #1;
         k += cpu_en;
         b += bus_en;
      end
      chk(k, 16);
      chk(b, 8);
      wreg(SCC_GATE, 32'h0000_00F5);
      wreg(SCC_LPKEEP, 32'h0000_0011);
      tick(2);
      chk(gate_en, 16'h00F5);
      low_power <= 1'b1;
      tick(3);
      chk(gate_en, 16'h0011);
      low_power <= 1'b0;
      wreg(SCC_TRIM, 32'h0000_330A);
      tick(2);
      chk(fi_trim, 5'h0A);
      chk(ms_trim, 8'h33);
      // Range 12 is out of the twelve settings
      wreg(SCC_OSC, 32'h0000_00CD);
      rreg(SCC_OSC);
      chk(rv, 32'h0000_006D);
      wreg(SCC_KSEL, 32'h0000_0003);
      tick(2);
      chk(ksel[1:0], KSEL_PLL);
      wreg(SCC_OSC, 32'h0000_036D);
      tick(20);
      wreg(SCC_KSEL, 32'h0000_0003);
      tick(2);
      chk(ksel[1:0], KSEL_MS);
      rreg(SCC_STAT);
      chk(rv[12], 1'b1);
      tick(200);
      chk(ms_trim == 8'h33, 1'b0);
      // Lose the fast external osc while it drives the core
      wreg(SCC_CFG, 32'h0000_0002);
      wreg(SCC_OSC, 32'h0000_236D);
      tick(20);
      chk(master_sel, SRC_FE);
      fail_cmd <= 1'b1;
      tick(20);
      chk(master_sel, SRC_FI);
      chk(fail_irq, 1'b1);
      rreg(SCC_CFG);
      chk(rv[1:0], SRC_FI);
      wreg(SCC_CLR, 32'h0000_0001);
      tick(3);
      chk(fail_irq, 1'b0);
      test_done();
   end
endmodule : testbench
